// ===== bench/pcl_env_model.sv
// Far-side model: supply monitor levels and fuse contents seen by the loader
`timescale 1ns/1ps
`default_nettype none

module pcl_env_model #(
    parameter logic [14:0] FUSE_TRIM = 15'h5A5A,
    parameter logic [31:0] FUSE_CAL  = 32'hC3D2_1234
) (
    input  wire logic        hclk,
    input  wire logic        dip_go,
    input  wire logic [7:0]  dip_cycles,
    output logic             supply_low,
    output logic             supply_high,
    output logic [14:0]      fused_trim_image,
    output logic [31:0]      fused_calibration_image
);
    int unsigned left = 0;

    // Fuses never change while powered
    assign fused_trim_image        = FUSE_TRIM;
    assign fused_calibration_image = FUSE_CAL;

    // ------------------------------------------------------------
    // Supply sag, then recovery past the upper threshold
    // ------------------------------------------------------------
    assign supply_low  = (left != 0);
    assign supply_high = (left == 0);

    always @(posedge hclk) begin
        if (dip_go && left == 0) begin
            left <= dip_cycles;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
endmodule

`default_nettype wire

// ===== bench/test_por_calibration_loader.sv
// Self-checking testbench for the power-on calibration loader
`timescale 1ns/1ps
`default_nettype none

module test_por_calibration_loader;
    // Short pulse count keeps each load sequence brief
    localparam int          P      = 4;
    localparam logic [14:0] F_TRIM = 15'h5A5A;
    localparam logic [31:0] F_CAL  = 32'hC3D2_1234;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_clock_present;
    logic [31:0] haddr, hwdata, hrdata, fused_calibration_image, rdv;
    logic [1:0]  htrans, op_mode;
    logic [2:0]  hsize;
    logic        supply_low, supply_high, ready_wake_pin, osc_enable, dip_go;
    logic [7:0]  dip_cycles;
    logic [16:0] threshold_count;
    logic [14:0] trim_out, chan_a_out, chan_b_out, fused_trim_image;
    logic [6:0]  common_out;
    logic [15:0] active_factor_out;
    int          bad_count, n_checks;

    pcl_loader #(.FUSE_PULSES(P)) pcl_loader_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .supply_low(supply_low), .supply_high(supply_high), .ext_clock_present(ext_clock_present),
        .fused_trim_image(fused_trim_image), .fused_calibration_image(fused_calibration_image),
        .ready_wake_pin(ready_wake_pin), .osc_enable(osc_enable), .op_mode(op_mode),
        .threshold_count(threshold_count), .trim_out(trim_out), .common_out(common_out),
        .chan_a_out(chan_a_out), .chan_b_out(chan_b_out), .active_factor_out(active_factor_out));

    pcl_env_model #(.FUSE_TRIM(F_TRIM), .FUSE_CAL(F_CAL)) pcl_env_model_i (
        .hclk(hclk), .dip_go(dip_go), .dip_cycles(dip_cycles), .supply_low(supply_low),
        .supply_high(supply_high), .fused_trim_image(fused_trim_image),
        .fused_calibration_image(fused_calibration_image));

    initial hclk = 1'b0;
    always #25 hclk = ~hclk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic test_done;
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic hang;
        bad_count++;
        $display("BAD %0t wait expired", $time);
        test_done;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) hang;
            @(posedge hclk);
        end
    endtask

    // One single-word transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy;
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy;
        rd = hrdata;
        chk(hresp, 1'b0);
    endtask

    // Counts load pulses until the mode leaves fuse load, then judges the outcome
    task automatic load_seq(input logic [1:0] mode, input logic osc);
        int   n, pulses;
        logic prev;
        n      = 0;
        pulses = 0;
        prev   = 1'b1;
        while (op_mode === pcl_pkg::MODE_FUSE_LOAD) begin
            @(negedge hclk);
            if (prev === 1'b1 && ready_wake_pin === 1'b0) pulses++;
            prev = ready_wake_pin;
            n++;
            if (n > 3000) hang;
        end
        chk(32'(pulses), 32'(P));
        chk(op_mode, mode);
        chk(osc_enable, osc);
        chk(threshold_count, pcl_pkg::THRESH_DEFAULT);
        chk(trim_out, F_TRIM);
        chk(active_factor_out, 16'h0000);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_power_up;
        fork
            load_seq(pcl_pkg::MODE_WAKE_UP, 1'b1);
            bus(1'b1, pcl_pkg::ADDR_TRIM, 32'h0000_7FFF, rdv);
        join
        @(posedge hclk);
        bus(1'b0, pcl_pkg::ADDR_TRIM, 32'h0, rdv);
        chk(rdv, {17'h0, F_TRIM});
        bus(1'b0, pcl_pkg::ADDR_CALIB, 32'h0, rdv);
        chk(rdv, {F_CAL[31:16], 16'h0000});
    endtask

    task automatic t_rewrite;
        // Tempco swept first, level trimmed afterwards
        for (int v = 0; v < 32; v++) begin
            bus(1'b1, pcl_pkg::ADDR_TRIM, {17'h0, 5'h03, 5'(v), 5'h00}, rdv);
            repeat (2) @(negedge hclk);
            chk(trim_out, {5'h03, 5'(v), 5'h00});
            @(posedge hclk);
        end
        bus(1'b1, pcl_pkg::ADDR_TRIM, {17'h0, 5'h03, 5'h1F, 5'h11}, rdv);
        bus(1'b0, pcl_pkg::ADDR_TRIM, 32'h0, rdv);
        chk(rdv, {17'h0, 5'h03, 5'h1F, 5'h11});
        bus(1'b1, pcl_pkg::ADDR_CALIB, {F_CAL[31:16], F_CAL[31:16]}, rdv);
        repeat (2) @(negedge hclk);
        chk(active_factor_out, F_CAL[31:16]);
    endtask

    task automatic t_config;
        @(posedge hclk);
        for (int r = 0; r < 4; r++) begin
            bus(1'b1, pcl_pkg::ADDR_COMMON, {25'h0, 2'(r), pcl_pkg::LEVEL_MAX}, rdv);
            bus(1'b0, pcl_pkg::ADDR_COMMON, 32'h0, rdv);
            chk(rdv, {25'h0, 2'(r), pcl_pkg::LEVEL_MAX});
            chk(common_out, {2'(r), pcl_pkg::LEVEL_MAX});
        end
        bus(1'b1, pcl_pkg::ADDR_CHAN_A, 32'h0000_1234, rdv);
        bus(1'b1, pcl_pkg::ADDR_CHAN_B, 32'h0000_4321, rdv);
        bus(1'b0, 8'h40, 32'h0, rdv);
        chk(rdv, 32'h0);
        chk(chan_a_out, 15'h1234);
        chk(chan_b_out, 15'h4321);
        bus(1'b1, pcl_pkg::ADDR_CONTROL, 32'h0000_0002, rdv);
        bus(1'b1, pcl_pkg::ADDR_CONTROL, 32'h0000_0000, rdv);
        bus(1'b0, pcl_pkg::ADDR_STATUS, 32'h0, rdv);
        chk(rdv, 32'h0000_0004);
        chk(op_mode, pcl_pkg::MODE_DUAL);
        bus(1'b1, pcl_pkg::ADDR_CONTROL, 32'h0000_0003, rdv);
    endtask

    task automatic t_brownout;
        int n;
        // Sag too short to count as a reset
        dip_cycles <= 8'h05;
        dip_go     <= 1'b1;
        @(posedge hclk);
        dip_go     <= 1'b0;
        repeat (40) @(posedge hclk);
        chk(op_mode, pcl_pkg::MODE_WAKE_UP);
        ext_clock_present <= 1'b1;
        dip_cycles        <= 8'h0E;
        dip_go            <= 1'b1;
        @(posedge hclk);
        dip_go <= 1'b0;
        n = 0;
        while (op_mode !== pcl_pkg::MODE_FUSE_LOAD) begin
            @(posedge hclk);
            n++;
            if (n > 200) hang;
        end
        load_seq(pcl_pkg::MODE_SINGLE, 1'b0);
        chk(chan_a_out, pcl_pkg::CHAN_DEFAULT);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        bad_count         = 0;
        n_checks          = 0;
        hresetn           = 1'b0;
        hsel              = 1'b0;
        haddr             = 32'h0;
        htrans            = 2'b00;
        hwrite            = 1'b0;
        hsize             = 3'b010;
        hwdata            = 32'h0;
        ext_clock_present = 1'b0;
        dip_go            = 1'b0;
        dip_cycles        = 8'h00;
        repeat (20) @(posedge hclk);
        chk(ready_wake_pin, 1'b1);
        chk(op_mode, pcl_pkg::MODE_FUSE_LOAD);
        chk(osc_enable, 1'b1);
        hresetn <= 1'b1;
        t_power_up;
        t_rewrite;
        t_config;
        t_brownout;
        test_done;
    end
endmodule

`default_nettype wire

// ===== hdl/pcl_loader.sv
// Power-on reset sequencer and calibration loader with AHB-Lite register slave
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module pcl_loader #(
    parameter int FUSE_PULSES = pcl_pkg::FUSE_PULSES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        supply_low,
    input  wire logic        supply_high,
    input  wire logic        ext_clock_present,
    input  wire logic [14:0] fused_trim_image,
    input  wire logic [31:0] fused_calibration_image,
    output logic             ready_wake_pin,
    output logic             osc_enable,
    output logic [1:0]       op_mode,
    output logic [16:0]      threshold_count,
    output logic [14:0]      trim_out,
    output logic [6:0]       common_out,
    output logic [14:0]      chan_a_out,
    output logic [14:0]      chan_b_out,
    output logic [15:0]      active_factor_out
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] low_sync;
    logic [1:0] high_sync;
    logic [1:0] ext_sync;
    logic       low_s;
    logic       high_s;
    logic       ext_s;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_sync  <= 2'h0;
            high_sync <= 2'h0;
            ext_sync  <= 2'h0;
        end else begin
            low_sync  <= {low_sync[0], supply_low};
            high_sync <= {high_sync[0], supply_high};
            ext_sync  <= {ext_sync[0], ext_clock_present};
        end
    end

    assign low_s  = low_sync[1];
    assign high_s = high_sync[1];
    assign ext_s  = ext_sync[1];

    // ------------------------------------------------------------
    // Brown-out detection and re-arm
    // ------------------------------------------------------------
    // Supply must dip long enough, then come fully back, before a reload starts;
    // the gap between the two thresholds gives hysteresis against a noisy rail.
    localparam int BW = $clog2(pcl_pkg::BROWNOUT_CYC + 1);
    logic [BW-1:0] low_cnt;
    logic          dipped;
    logic          restart;
    wire           dip_long = (low_cnt == BW'(pcl_pkg::BROWNOUT_CYC));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt <= '0;
            dipped  <= 1'b0;
        end else begin
            if (!low_s)
                low_cnt <= '0;
            else if (!dip_long)
                low_cnt <= low_cnt + BW'(1);
            if (dip_long)
                dipped <= 1'b1;
            else if (high_s && !low_s)
                dipped <= 1'b0;
        end
    end

    assign restart = dipped && high_s && !low_s;

    // ------------------------------------------------------------
    // Load sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_START = 2'b00,
        SEQ_PULSE = 2'b01,
        SEQ_DONE  = 2'b10
    } pcl_seq_type;

    localparam int PW = $clog2(FUSE_PULSES + 1);
    pcl_seq_type   seq;
    pcl_seq_type   next_seq;
    logic [PW-1:0] pulse_cnt;
    logic          phase;
    wire           last_pulse = (pulse_cnt == PW'(FUSE_PULSES - 1)) && phase;

    always_comb begin
        next_seq = seq;
        unique case (seq)
            SEQ_START: next_seq = SEQ_PULSE;
            SEQ_PULSE: if (last_pulse) next_seq = SEQ_DONE;
            SEQ_DONE:  next_seq = SEQ_DONE;
            default:   next_seq = SEQ_START;
        endcase
        if (restart)
            next_seq = SEQ_START;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq       <= SEQ_START;
            pulse_cnt <= '0;
            phase     <= 1'b0;
        end else begin
            seq <= next_seq;
            if (next_seq != SEQ_PULSE || seq != SEQ_PULSE) begin
                pulse_cnt <= '0;
                phase     <= 1'b0;
            end else begin
                phase <= ~phase;
                if (phase)
                    pulse_cnt <= pulse_cnt + PW'(1);
            end
        end
    end

    wire loading = (seq != SEQ_DONE);

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic       dp_write;
    logic [7:0] dp_addr;
    wire        take = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end else begin
            dp_write <= take && hwrite;
            dp_addr  <= take ? haddr[7:0] : dp_addr;
        end
    end

    // Writes during loading are dropped; after loading, bus writes can overwrite the fused values
    wire wr_ok   = dp_write && !loading;
    wire wr_trim = wr_ok && dp_addr == pcl_pkg::ADDR_TRIM;
    wire wr_cal  = wr_ok && dp_addr == pcl_pkg::ADDR_CALIB;
    wire wr_com  = wr_ok && dp_addr == pcl_pkg::ADDR_COMMON;
    wire wr_cha  = wr_ok && dp_addr == pcl_pkg::ADDR_CHAN_A;
    wire wr_chb  = wr_ok && dp_addr == pcl_pkg::ADDR_CHAN_B;
    wire wr_ctl  = wr_ok && dp_addr == pcl_pkg::ADDR_CONTROL;

    // ------------------------------------------------------------
    // Working registers
    // ------------------------------------------------------------
    pcl_pkg::pcl_trim_type   trim_reg;
    pcl_pkg::pcl_calib_type  calib_reg;
    pcl_pkg::pcl_common_type common_reg;
    pcl_pkg::pcl_chan_type   chan_a;
    pcl_pkg::pcl_chan_type   chan_b;
    pcl_pkg::pcl_mode_type   mode;

    wire pcl_pkg::pcl_common_type com_wr = pcl_pkg::pcl_common_type'(hwdata[6:0]);
    // Level codes above 31 cannot occur; the field is five bits wide
    wire [4:0] level_clamped = com_wr.current_level;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trim_reg   <= pcl_pkg::TRIM_RESET;
            calib_reg  <= pcl_pkg::CALIB_RESET;
            common_reg <= pcl_pkg::COMMON_RESET;
            chan_a     <= pcl_pkg::CHAN_DEFAULT;
            chan_b     <= pcl_pkg::CHAN_DEFAULT;
            mode       <= pcl_pkg::MODE_FUSE_LOAD;
        end else if (restart || seq == SEQ_START) begin
            mode <= pcl_pkg::MODE_FUSE_LOAD;
        end else if (seq == SEQ_PULSE && last_pulse) begin
            trim_reg  <= fused_trim_image;
            calib_reg <= {fused_calibration_image[31:16], 16'h0000};
            common_reg <= pcl_pkg::COMMON_RESET;
            chan_a    <= pcl_pkg::CHAN_DEFAULT;
            chan_b    <= pcl_pkg::CHAN_DEFAULT;
            mode      <= ext_s ? pcl_pkg::MODE_SINGLE
                               : pcl_pkg::MODE_WAKE_UP;
        end else begin
            if (wr_trim)
                trim_reg <= hwdata[14:0];
            if (wr_cal)
                calib_reg <= hwdata;
            if (wr_com)
                common_reg <= {com_wr.source_route, level_clamped};
            if (wr_cha)
                chan_a <= hwdata[14:0];
            if (wr_chb)
                chan_b <= hwdata[14:0];
            if (wr_ctl && hwdata[1:0] != pcl_pkg::MODE_FUSE_LOAD)
                mode <= pcl_pkg::pcl_mode_type'(hwdata[1:0]);
        end
    end

    // ------------------------------------------------------------
    // Read mux and outputs
    // ------------------------------------------------------------
    wire [31:0] status_word = {28'h0, ext_s, mode, loading};
    // Captured in the address phase so the word stands through the whole data phase
    wire [31:0] rd_mux = (haddr[7:0] == pcl_pkg::ADDR_TRIM)    ? {17'h0, trim_reg}   :
                         (haddr[7:0] == pcl_pkg::ADDR_CALIB)   ? calib_reg           :
                         (haddr[7:0] == pcl_pkg::ADDR_COMMON)  ? {25'h0, common_reg} :
                         (haddr[7:0] == pcl_pkg::ADDR_CHAN_A)  ? {17'h0, chan_a}     :
                         (haddr[7:0] == pcl_pkg::ADDR_CHAN_B)  ? {17'h0, chan_b}     :
                         (haddr[7:0] == pcl_pkg::ADDR_STATUS)  ? status_word         :
                         (haddr[7:0] == pcl_pkg::ADDR_CONTROL) ? {30'h0, mode}       :
                         32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata            <= 32'h0000_0000;
            ready_wake_pin    <= 1'b1;
            osc_enable        <= 1'b1;
            op_mode           <= pcl_pkg::MODE_FUSE_LOAD;
            threshold_count   <= pcl_pkg::THRESH_DEFAULT;
            trim_out          <= pcl_pkg::TRIM_RESET;
            common_out        <= pcl_pkg::COMMON_RESET;
            chan_a_out        <= pcl_pkg::CHAN_DEFAULT;
            chan_b_out        <= pcl_pkg::CHAN_DEFAULT;
            active_factor_out <= 16'h0000;
        end else begin
            hrdata            <= (take && !hwrite) ? rd_mux : hrdata;
            ready_wake_pin    <= !(seq == SEQ_PULSE && next_seq == SEQ_PULSE && !phase);
            osc_enable        <= loading || mode == pcl_pkg::MODE_WAKE_UP || !ext_s;
            op_mode           <= mode;
            threshold_count   <= pcl_pkg::THRESH_DEFAULT;
            trim_out          <= trim_reg;
            common_out        <= common_reg;
            chan_a_out        <= chan_a;
            chan_b_out        <= chan_b;
            active_factor_out <= calib_reg.gain100_active_factor;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [PW-1:0] low_seen;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            low_seen <= '0;
        else if (seq == SEQ_START || !ready_wake_pin)
            low_seen <= (seq == SEQ_START) ? '0 : low_seen + PW'(1);
    end
    property p_pulse_count;
        @(posedge hclk) disable iff (!hresetn)
        (seq == SEQ_PULSE && next_seq == SEQ_DONE) |=> low_seen == PW'(FUSE_PULSES);
    endproperty
    a_pulse_count: assert property (p_pulse_count) else $error("pulse count wrong at end");

    property p_no_measure_while_loading;
        @(posedge hclk) disable iff (!hresetn)
        loading |-> mode == pcl_pkg::MODE_FUSE_LOAD;
    endproperty
    a_no_measure_while_loading: assert property (p_no_measure_while_loading) else $error("mode left too early");

    property p_mode_after_load;
        @(posedge hclk) disable iff (!hresetn)
        (seq == SEQ_PULSE && last_pulse && !restart) |=>
            mode == (ext_s ? pcl_pkg::MODE_SINGLE : pcl_pkg::MODE_WAKE_UP);
    endproperty
    a_mode_after_load: assert property (p_mode_after_load) else $error("wrong mode after load");

    property p_active_zero;
        @(posedge hclk) disable iff (!hresetn)
        (seq == SEQ_PULSE && last_pulse && !restart) |=> calib_reg.gain100_active_factor == 16'h0000;
    endproperty
    a_active_zero: assert property (p_active_zero) else $error("active factor not cleared");

    property p_trim_loaded;
        @(posedge hclk) disable iff (!hresetn)
        (seq == SEQ_PULSE && last_pulse && !restart) |=> trim_reg == $past(fused_trim_image);
    endproperty
    a_trim_loaded: assert property (p_trim_loaded) else $error("trim image not loaded");

    property p_restart;
        @(posedge hclk) disable iff (!hresetn)
        restart |=> seq == SEQ_START ##1 mode == pcl_pkg::MODE_FUSE_LOAD;
    endproperty
    a_restart: assert property (p_restart) else $error("restart not taken");

    property p_trim_write;
        @(posedge hclk) disable iff (!hresetn)
        (wr_trim && seq == SEQ_DONE) |=> ##1 trim_out == $past(hwdata[14:0], 2);
    endproperty
    a_trim_write: assert property (p_trim_write) else $error("trim write not applied");

    property p_pin_pulses;
        @(posedge hclk) disable iff (!hresetn)
        (seq == SEQ_DONE) [*2] |-> ready_wake_pin;
    endproperty
    a_pin_pulses: assert property (p_pin_pulses) else $error("pin pulsing after load");

endmodule

`default_nettype wire

// ===== inc/pcl_pkg.sv
// Package for the power-on calibration loader: register map, layouts, timing constants
package pcl_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TRIM     = 8'h00;
    localparam logic [7:0] ADDR_CALIB    = 8'h04;
    localparam logic [7:0] ADDR_COMMON   = 8'h08;
    localparam logic [7:0] ADDR_CHAN_A   = 8'h0C;
    localparam logic [7:0] ADDR_CHAN_B   = 8'h10;
    localparam logic [7:0] ADDR_STATUS   = 8'h14;
    localparam logic [7:0] ADDR_CONTROL  = 8'h18;
    localparam logic [7:0] ADDR_FUSE_TRM = 8'h1C;
    localparam logic [7:0] ADDR_FUSE_CAL = 8'h20;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    // Trim register: ref level [4:0], ref tempco [9:5], current source [14:10]
    typedef struct packed {
        logic [4:0] current_source_trim;
        logic [4:0] ref_tempco_trim;
        logic [4:0] ref_level_trim;
    } pcl_trim_type;

    // Calibration factor register: stored gain100 [31:16], active gain100 [15:0]
    typedef struct packed {
        logic [15:0] gain100_stored_factor;
        logic [15:0] gain100_active_factor;
    } pcl_calib_type;

    // Common config: current level [4:0], source route [6:5]
    typedef struct packed {
        logic [1:0] source_route;
        logic [4:0] current_level;
    } pcl_common_type;

    // Channel config: mux [3:0], gain [6:4], oversample ratio [9:7], chop [11:10], avg [14:12]
    typedef struct packed {
        logic [2:0] averaging_ratio;
        logic [1:0] chop_ratio;
        logic [2:0] oversampling_ratio;
        logic [2:0] gain_sel;
        logic [3:0] mux_sel;
    } pcl_chan_type;

    typedef enum logic [1:0] {
        MODE_FUSE_LOAD    = 2'b00,
        MODE_SINGLE       = 2'b01,
        MODE_DUAL         = 2'b10,
        MODE_WAKE_UP      = 2'b11
    } pcl_mode_type;

    typedef enum logic [1:0] {
        ROUTE_OFF    = 2'b00,
        ROUTE_VBAT   = 2'b01,
        ROUTE_SENSE  = 2'b10,
        ROUTE_RETURN = 2'b11
    } pcl_route_type;

    // ------------------------------------------------------------
    // Reset values and defaults
    // ------------------------------------------------------------
    localparam logic [14:0] TRIM_RESET    = 15'h0000;
    localparam logic [31:0] CALIB_RESET   = 32'h0000_0000;
    localparam logic [6:0]  COMMON_RESET  = 7'h00;
    // Single-measure default: gain 100 code 4, ratio 64 code 3, chop 4 code 2, avg 1 code 0
    localparam logic [14:0] CHAN_DEFAULT  = 15'h09C0;
    localparam logic [16:0] THRESH_DEFAULT = 17'h04000;
    localparam logic [4:0]  LEVEL_MAX     = 5'h1F;
    localparam int          CURRENT_STEP_UA = 8;
    localparam int          REF_STEP_UV   = 5100;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_MHZ        = 20;
    localparam int          BROWNOUT_NS    = 500;
    localparam int          BROWNOUT_CYC   = (BROWNOUT_NS * CLK_MHZ + 999) / 1000;
    localparam int          FUSE_PULSES    = 188;
    localparam int          SETTLE_CYC     = 4;

endpackage
